// >>> rtl/gdhs_top.sv
// Purpose: high-side gate drive config register with map lock
// Assumes: classic Wishbone slave, 32-bit data, one clock
// Notes:   ack one cycle after request, dropped the next cycle
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Writing 110b to the lock field while unlocked locks the map except the lock field and ctrl bits 0-2.
// - While unlocked, other lock codes leave the lock state alone.
// - Writing 011b to the lock field unlocks every register.
// - While locked, codes other than 011b keep the map locked.
// - The source current code sits at bits 7:4, read/write, reset 1111b.
// - The sink current code sits at bits 3:0, read/write, reset 1111b.
// - The config register lives at register index 0x03.
// - Ctrl bit 2 coasts, bit 1 brakes, bit 0 clears faults and self-clears.
module gdhs_top
   import gdhs_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        CE,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [3:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic      [3:0]  HS_SOURCE_CURRENT_CODE,
   output logic      [3:0]  HS_SINK_CURRENT_CODE,
   output logic             COAST,
   output logic             BRAKE,
   output logic             FAULT_CLEAR,
   output logic             LOCKED
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [2:0]            lock_code_r, lock_code_nxt;
   logic [3:0]            src_r, src_nxt;
   logic [3:0]            snk_r, snk_nxt;
   logic [GDHS_CTL_W-1:0] ctl_r, ctl_nxt;
   logic                  ack_r, ack_nxt;
   logic [31:0]           dat_r, dat_nxt;
   logic                  req;
   logic                  wr;
   gdhs_lock_if           lk ();

   gdhs_lock u_lock (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ce      (CE),
      .lk      (lk)
   );

   // ----------------------------------------
   // bus and register next state
   // ----------------------------------------
   assign req = WB_CYC_I && WB_STB_I && !ack_r;
   assign wr  = req && WB_WE_I;

   always_comb begin
      lock_code_nxt = lock_code_r;
      src_nxt       = src_r;
      snk_nxt       = snk_r;
      ctl_nxt       = ctl_r;
      ctl_nxt[GDHS_CTL_CLR] = 1'b0;
      ack_nxt       = req;
      dat_nxt       = dat_r;
      lk.lock_wr    = 1'b0;
      lk.lock_data  = WB_DAT_I[GDHS_LOCK_LSB +: 3];
      if (wr && WB_ADR_I == GDHS_HS_CFG) begin
         if (WB_SEL_I[1]) begin
            lock_code_nxt = WB_DAT_I[GDHS_LOCK_LSB +: 3];
            lk.lock_wr    = 1'b1;
         end
         if (WB_SEL_I[0] && !lk.locked) begin
            src_nxt = WB_DAT_I[GDHS_SRC_LSB +: 4];
            snk_nxt = WB_DAT_I[GDHS_SNK_LSB +: 4];
         end
      end
      if (wr && WB_ADR_I == GDHS_DRV_CTRL) begin
         if (WB_SEL_I[0]) begin
            ctl_nxt[2:0] = WB_DAT_I[2:0];
            if (!lk.locked) begin
               ctl_nxt[7:3] = WB_DAT_I[7:3];
            end
         end
         if (WB_SEL_I[1] && !lk.locked) begin
            ctl_nxt[10:8] = WB_DAT_I[10:8];
         end
      end
      if (req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            GDHS_HS_CFG:   dat_nxt = {21'h0, lock_code_r, src_r, snk_r};
            GDHS_DRV_CTRL: dat_nxt = {21'h0, ctl_r};
            default:       dat_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lock_code_r <= GDHS_LOCK_RST;
         src_r       <= GDHS_SRC_RST;
         snk_r       <= GDHS_SNK_RST;
         ctl_r       <= GDHS_CTL_RST;
         ack_r       <= 1'b0;
         dat_r       <= 32'h00000000;
      end else if (CE) begin
         lock_code_r <= lock_code_nxt;
         src_r       <= src_nxt;
         snk_r       <= snk_nxt;
         ctl_r       <= ctl_nxt;
         ack_r       <= ack_nxt;
         dat_r       <= dat_nxt;
      end
   end

   assign WB_ACK_O               = ack_r;
   assign WB_DAT_O               = dat_r;
   assign HS_SOURCE_CURRENT_CODE = src_r;
   assign HS_SINK_CURRENT_CODE   = snk_r;
   assign COAST                  = ctl_r[GDHS_CTL_COAST];
   assign BRAKE                  = ctl_r[GDHS_CTL_BRAKE];
   assign FAULT_CLEAR            = ctl_r[GDHS_CTL_CLR];
   assign LOCKED                 = lk.locked;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   locked_codes_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      CE && lk.locked |=> $stable(src_r) && $stable(snk_r))
      else $error("drive code changed while locked");
   clear_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      CE && ctl_r[GDHS_CTL_CLR] |=> !ctl_r[GDHS_CTL_CLR])
      else $error("fault clear did not self-clear");
   coast_open_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      CE && wr && WB_ADR_I == GDHS_DRV_CTRL && WB_SEL_I[0]
      |=> ctl_r[GDHS_CTL_COAST] == $past(WB_DAT_I[GDHS_CTL_COAST]))
      else $error("coast write lost");
   src_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      CE && wr && WB_ADR_I == GDHS_HS_CFG && WB_SEL_I[0] && !lk.locked
      |=> src_r == $past(WB_DAT_I[7:4]) && snk_r == $past(WB_DAT_I[3:0]))
      else $error("config write lost while unlocked");
   ack_once_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      CE && ack_r |=> !ack_r)
      else $error("ack held two cycles");
endmodule // gdhs_top
`default_nettype wire

// >>> rtl/gdhs_pkg.sv
// Purpose: constants for the high-side gate drive config and lock block
// Assumes: classic Wishbone, 32-bit data, word-aligned registers
// Notes:   lock codes and field layout shared by main and lock modules
package gdhs_pkg;
   localparam int          GDHS_AW         = 4;
   // register byte addresses
   localparam logic [3:0]  GDHS_DRV_CTRL   = 4'h8;   // index 0x02
   localparam logic [3:0]  GDHS_HS_CFG     = 4'hC;   // index 0x03
   // field layout
   localparam int          GDHS_LOCK_LSB   = 8;
   localparam int          GDHS_SRC_LSB    = 4;
   localparam int          GDHS_SNK_LSB    = 0;
   localparam int          GDHS_CTL_COAST  = 2;
   localparam int          GDHS_CTL_BRAKE  = 1;
   localparam int          GDHS_CTL_CLR    = 0;
   localparam int          GDHS_CTL_W      = 11;
   // reset values and lock codes
   localparam logic [2:0]  GDHS_LOCK_RST   = 3'h3;
   localparam logic [2:0]  GDHS_LOCK_CODE  = 3'h6;
   localparam logic [2:0]  GDHS_UNLOCK_CODE = 3'h3;
   localparam logic [3:0]  GDHS_SRC_RST    = 4'hF;
   localparam logic [3:0]  GDHS_SNK_RST    = 4'hF;
   localparam logic [10:0] GDHS_CTL_RST    = 11'h000;
endpackage

// >>> rtl/gdhs_lock_if.sv
// Purpose: carrier between register front end and lock keeper
// Assumes: single clock domain
// Notes:   lock_wr is a one-cycle strobe
`timescale 1ns/1ns
`default_nettype none
interface gdhs_lock_if;
   logic       lock_wr;
   logic [2:0] lock_data;
   logic       locked;
   modport keeper (input lock_wr, input lock_data, output locked);
   modport user   (output lock_wr, output lock_data, input locked);
endinterface
`default_nettype wire

// >>> rtl/gdhs_lock.sv
// Purpose: lock state keeper for the register map
// Assumes: lock_wr pulses once per accepted write to the lock field
// Notes:   locked state is kept apart from the readback code
`timescale 1ns/1ns
`default_nettype none
module gdhs_lock
   import gdhs_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    reset_n,
   input  wire logic    ce,
   gdhs_lock_if.keeper  lk
);
   logic locked_r;
   logic locked_nxt;

   always_comb begin
      locked_nxt = locked_r;
      if (lk.lock_wr) begin
         if (!locked_r && lk.lock_data == GDHS_LOCK_CODE) begin
            locked_nxt = 1'b1;
         end
         if (locked_r && lk.lock_data == GDHS_UNLOCK_CODE) begin
            locked_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         locked_r <= 1'b0;
      end else if (ce) begin
         locked_r <= locked_nxt;
      end
   end

   assign lk.locked = locked_r;

   stay_unlocked_a: assert property (@(posedge clk) disable iff (!reset_n)
      ce && lk.lock_wr && !locked_r && lk.lock_data != GDHS_LOCK_CODE |=> !locked_r)
      else $error("lock set by a non-lock code");
   stay_locked_a: assert property (@(posedge clk) disable iff (!reset_n)
      ce && lk.lock_wr && locked_r && lk.lock_data != GDHS_UNLOCK_CODE |=> locked_r)
      else $error("lock released by a non-unlock code");
   lock_code_a: assert property (@(posedge clk) disable iff (!reset_n)
      ce && lk.lock_wr && !locked_r && lk.lock_data == GDHS_LOCK_CODE |=> locked_r)
      else $error("lock code did not lock");
   unlock_code_a: assert property (@(posedge clk) disable iff (!reset_n)
      ce && lk.lock_wr && locked_r && lk.lock_data == GDHS_UNLOCK_CODE |=> !locked_r)
      else $error("unlock code did not unlock");
endmodule // gdhs_lock
`default_nettype wire

// >>> verification/gdhs_host.sv
// Purpose: wishbone host model that reaches the register port
// Assumes: classic single cycle, one clock, stb follows cyc
// Notes:   ack wait is unbounded; the bench watchdog ends a hang
`timescale 1ns/1ns
`default_nettype none
module gdhs_host (
   input  wire logic        clk,
   input  wire logic        ack,
   output logic             cyc,
   output logic             we,
   output logic      [3:0]  sel,
   output logic      [3:0]  adr,
   output logic      [31:0] dat
);
   initial begin
      cyc = 1'b0;
      we  = 1'b0;
      sel = 4'hF;
      adr = 4'h0;
      dat = 32'h0;
   end
   // request held until ack is sampled; released data is inverted, not left stale
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF);
      @(posedge clk);
      cyc <= 1'b1;
      we  <= w;
      sel <= s;
      adr <= a;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0;
      dat <= ~d;
   endtask
endmodule // gdhs_host
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the gate drive config and lock register
// Assumes: host model issues every bus cycle
// Notes:   reads queue their expectation; a monitor compares at ack
`timescale 1ns/1ns
`default_nettype none
module tb;
   import gdhs_pkg::*;
   logic        clk, rst_n, ack, we, cyc, coast, brake, fclr, locked, fclr_seen;
   logic [3:0]  adr, src, snk, sel;
   logic [31:0] dat, rdat;
   logic [31:0] exp_q[$];
   logic [7:0]  seed, keep;
   int          mismatches, checks_done;
   gdhs_host host (.clk(clk), .ack(ack), .cyc(cyc), .we(we), .sel(sel), .adr(adr), .dat(dat));
   gdhs_top uut (.CLK(clk), .RESET_N(rst_n), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(cyc),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .HS_SOURCE_CURRENT_CODE(src), .HS_SINK_CURRENT_CODE(snk),
      .COAST(coast), .BRAKE(brake), .FAULT_CLEAR(fclr), .LOCKED(locked));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 32'h0);
   endtask
   task automatic cfg(input logic [2:0] k, input logic [7:0] d, input logic [7:0] e,
                      input logic l);
      host.xfer(1'b1, GDHS_HS_CFG, {21'h0, k, d});
      rd(GDHS_HS_CFG, {21'h0, k, e});
      chk("codes", 32'(e), 32'({src, snk}));
      chk("locked", 32'(l), 32'(locked));
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk("read", exp_q.pop_front(), rdat);
      if (fclr === 1'b1) fclr_seen <= 1'b1;
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      seed = 8'h07;
      fclr_seen = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(GDHS_HS_CFG, 32'h3FF);
      chk("locked", 32'h0, 32'(locked));
      $display("test reset done");
      // no lock code but 110b locks from unlocked
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         if (k != 6) cfg(3'(k), seed, seed, 1'b0);
      end
      seed = lfsr(seed);
      keep = seed;
      cfg(3'h6, seed, seed, 1'b1);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         if (k != 3) cfg(3'(k), seed, keep, 1'b1);
      end
      $display("test lock codes done");
      host.xfer(1'b1, GDHS_DRV_CTRL, 32'h7FF);
      rd(GDHS_DRV_CTRL, 32'h006);
      chk("coast brake", 32'h3, 32'({coast, brake}));
      chk("fault clear", 32'h1, 32'(fclr_seen));
      $display("test locked ctrl done");
      cfg(3'h3, ~keep, keep, 1'b0);
      cfg(3'h5, ~keep, ~keep, 1'b0);
      host.xfer(1'b1, GDHS_DRV_CTRL, 32'h7F8);
      rd(GDHS_DRV_CTRL, 32'h7F8);
      chk("coast brake", 32'h0, 32'({coast, brake}));
      host.xfer(1'b1, GDHS_HS_CFG, {21'h0, 3'h2, keep}, 4'h2);
      rd(GDHS_HS_CFG, {21'h0, 3'h2, ~keep});
      host.xfer(1'b1, 4'h4, 32'hFFFF);
      rd(4'h4, 32'h0);
      $display("test unlock done");
      wrap_up();
   end
endmodule // tb
`default_nettype wire
